// [design/flow_cmd_pkg.sv]
package flow_cmd_pkg;

  // ----------------------------------------------------------------
  // link addressing and framing
  // ----------------------------------------------------------------
  localparam logic [6:0] TARGET_ADDR = 7'h29;
  localparam logic [3:0] WR_BYTES_PLAIN = 4'h2;
  localparam logic [3:0] WR_BYTES_ARG = 4'h5;
  localparam logic [3:0] RD_LAST_IDX = 4'h8;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_FULL = 4'h8;

  // ----------------------------------------------------------------
  // command codes
  // ----------------------------------------------------------------
  localparam logic [15:0] CMD_START_O2 = 16'h3603;
  localparam logic [15:0] CMD_START_AIR = 16'h3608;
  localparam logic [15:0] CMD_START_MIX = 16'h3632;
  localparam logic [15:0] CMD_STOP = 16'h3FF9;
  localparam logic [15:0] CMD_CONC = 16'hE17D;
  localparam logic [15:0] CMD_PTR_RESET = 16'hE000;

  // ----------------------------------------------------------------
  // status word fields
  // ----------------------------------------------------------------
  localparam logic [3:0] MODE_O2 = 4'h0;
  localparam logic [3:0] MODE_AIR = 4'h1;
  localparam logic [3:0] MODE_MIX = 4'h6;
  localparam logic [9:0] CONC_PURE = 10'h3FF;
  localparam logic [15:0] CONC_MAX = 16'h03E8;
  localparam int STAT_MODE_LSB = 12;
  localparam int STAT_EXP_BIT = 11;
  localparam int STAT_AVG_BIT = 10;

  // ----------------------------------------------------------------
  // checksum
  // ----------------------------------------------------------------
  localparam logic [7:0] CRC_POLY = 8'h31;
  localparam logic [7:0] CRC_INIT = 8'hFF;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_KHZ = 10000;
  localparam int WARM_US = 12000;
  localparam int STOP_US = 500;
  localparam int SMOOTH_US = 64000;
  localparam int WARM_CYCLES = (WARM_US * CLK_KHZ + 999) / 1000;
  localparam int STOP_CYCLES = (STOP_US * CLK_KHZ) / 1000;
  localparam int SMOOTH_CYCLES = (SMOOTH_US * CLK_KHZ) / 1000;

endpackage : flow_cmd_pkg

// [design/word_checksum.sv]
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------------
// crc over one 16-bit word, high byte first
// ------------------------------------------------------------------
module word_checksum (
  // word in
  input wire logic [15:0] i_word,
  // checksum out
  output logic [7:0] o_crc
);

  always_comb begin
    logic [7:0] c;
    c = flow_cmd_pkg::CRC_INIT;
    for (int i = 15; i >= 0; i--) begin
      if (c[7] ^ i_word[i]) begin
        c = {c[6:0], 1'b0} ^ flow_cmd_pkg::CRC_POLY;
      end else begin
        c = {c[6:0], 1'b0};
      end
    end
    o_crc = c;
  end

endmodule : word_checksum

`default_nettype wire

// [design/flow_cmd_target.sv]
// Operation
// - answer as serial-bus target at address 0x29, read/write bit follows
// - every command is a 16-bit code sent as two bytes after write header
// - argument commands carry a 16-bit argument then its 8-bit checksum
// - read words go high byte first, each followed by a checksum byte
// - controller NACK then STOP ends a read; data line is released
// - 0x3603 oxygen, 0x3608 air, 0x3632 mixture with per mille argument
// - once started, each read header returns the latest three words
// - first result readable 12 ms after a start command
// - read header with no data available is answered with NACK
// - read gives flow, checksum, temperature, checksum, status, checksum
// - flow and temperature are raw signed 16-bit values
// - status bits 15:12 encode the running start command
// - status bit 11 exponential smoothing, bit 10 fixed-count averaging
// - status bits 9:0 are 0x3FF for pure gas, else oxygen per mille (0xE17D also sets them in oxygen and air modes)
// - 0xE17D with argument updates mixture concentration while running
// - 0xE000 points read headers back at normal results, no restart
// - concentration above 1000 stops the running measurement
// - mixture start argument applies at once, no pointer reset needed
// - 0x3FF9 stops measurement; new commands accepted within 0.5 ms
// - while measuring only stop, concentration and pointer reset commands are accepted
// - average-until-read with no readout for 64 ms turns on smoothing
//
`timescale 1ns/1ps
`default_nettype none

module flow_cmd_target #(
  parameter int WARM_CYC = flow_cmd_pkg::WARM_CYCLES,
  parameter int STOP_CYC = flow_cmd_pkg::STOP_CYCLES,
  parameter int SMOOTH_CYC = flow_cmd_pkg::SMOOTH_CYCLES
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // serial link pins
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_out,
  output logic o_sda_oe,
  // measurement results
  input wire logic [15:0] i_flow,
  input wire logic [15:0] i_temp,
  input wire logic i_avg_fixed,
  // measurement control and status
  output logic o_meas_active,
  output logic o_data_ready,
  output logic [3:0] o_meas_mode,
  output logic [9:0] o_conc,
  output logic o_exp_smooth,
  output logic o_cmd_reject
);

  typedef enum {S_IDLE, S_ADDR, S_WR, S_ACK, S_RD, S_RD_ACK} link_st_t;
  typedef enum {M_IDLE, M_WARM, M_RUN, M_STOPPING} meas_st_t;

  link_st_t st;
  meas_st_t mst;
  logic scl_s1, scl_s2, scl_q, sda_s1, sda_s2, sda_q;
  logic scl_rise, scl_fall, bus_start, bus_stop;
  logic [3:0] bit_cnt;
  logic [7:0] rx_sh, tx_sh;
  logic is_read, wr_active, master_ack;
  logic [3:0] wr_cnt, rd_idx, sel_idx;
  logic [7:0] wr_buf [0:4];
  logic [15:0] snap_flow, snap_temp, snap_stat, sel_word, status_word;
  logic [7:0] sel_crc, arg_crc, sel_byte;
  logic rd_ok, exec, rd_event, ptr_moved, exp_on;
  logic [15:0] cmd, arg;
  logic arg_ok;
  logic [19:0] wait_cnt, avg_cnt;

  // ----------------------------------------------------------------
  // pin synchronisers and bus events
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_q <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_s1 <= i_scl;
      scl_s2 <= scl_s1;
      scl_q <= scl_s2;
      sda_s1 <= i_sda;
      sda_s2 <= sda_s1;
      sda_q <= sda_s2;
    end
  end

  assign scl_rise = scl_s2 && !scl_q;
  assign scl_fall = !scl_s2 && scl_q;
  assign bus_start = scl_s2 && scl_q && sda_q && !sda_s2;
  assign bus_stop = scl_s2 && scl_q && !sda_q && sda_s2;

  // ----------------------------------------------------------------
  // read data selection and checksums
  // ----------------------------------------------------------------
  assign status_word = {o_meas_mode, exp_on, i_avg_fixed, o_conc};
  assign sel_idx = (st == S_RD_ACK) ? rd_idx + 4'h1 : 4'h0;

  always_comb begin
    if (sel_idx < 4'h3) begin
      sel_word = snap_flow;
    end else if (sel_idx < 4'h6) begin
      sel_word = snap_temp;
    end else begin
      sel_word = snap_stat;
    end
    case (sel_idx)
      4'h0, 4'h3, 4'h6: sel_byte = sel_word[15:8];
      4'h1, 4'h4, 4'h7: sel_byte = sel_word[7:0];
      default: sel_byte = sel_crc;
    endcase
  end

  word_checksum u_rd_crc (
    .i_word(sel_word),
    .o_crc(sel_crc)
  );

  assign cmd = {wr_buf[0], wr_buf[1]};
  assign arg = {wr_buf[2], wr_buf[3]};

  word_checksum u_arg_crc (
    .i_word(arg),
    .o_crc(arg_crc)
  );

  assign arg_ok = (wr_cnt == flow_cmd_pkg::WR_BYTES_ARG) && (arg_crc == wr_buf[4]);
  assign rd_ok = (mst == M_RUN) && !ptr_moved;
  assign exec = wr_active && (bus_start || bus_stop);
  assign o_sda_out = 1'b0;

  // ----------------------------------------------------------------
  // serial target state machine
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      st <= S_IDLE;
      bit_cnt <= 4'h0;
      rx_sh <= 8'h00;
      tx_sh <= 8'h00;
      is_read <= 1'b0;
      wr_active <= 1'b0;
      master_ack <= 1'b0;
      wr_cnt <= 4'h0;
      rd_idx <= 4'h0;
      o_sda_oe <= 1'b0;
      rd_event <= 1'b0;
      snap_flow <= 16'h0000;
      snap_temp <= 16'h0000;
      snap_stat <= 16'h0000;
      for (int i = 0; i < 5; i++) begin
        wr_buf[i] <= 8'h00;
      end
    end else begin
      rd_event <= 1'b0;
      if (bus_start || bus_stop) begin
        st <= bus_start ? S_ADDR : S_IDLE;
        bit_cnt <= 4'h0;
        o_sda_oe <= 1'b0;
        wr_active <= 1'b0;
      end else begin
        case (st)
          S_ADDR, S_WR: begin
            if (scl_rise) begin
              rx_sh <= {rx_sh[6:0], sda_s2};
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall && bit_cnt == flow_cmd_pkg::BIT_FULL) begin
              bit_cnt <= 4'h0;
              if (st == S_ADDR) begin
                is_read <= rx_sh[0];
                wr_cnt <= 4'h0;
                rd_idx <= 4'h0;
                if (rx_sh[7:1] == flow_cmd_pkg::TARGET_ADDR &&
                    (rx_sh[0] ? rd_ok : (mst != M_STOPPING))) begin
                  st <= S_ACK;
                  o_sda_oe <= 1'b1;
                  wr_active <= !rx_sh[0];
                  if (rx_sh[0]) begin
                    snap_flow <= i_flow;
                    snap_temp <= i_temp;
                    snap_stat <= status_word;
                    rd_event <= 1'b1;
                  end
                end else begin
                  st <= S_IDLE;
                end
              end else if (wr_cnt < flow_cmd_pkg::WR_BYTES_ARG) begin
                wr_buf[wr_cnt[2:0]] <= rx_sh;
                wr_cnt <= wr_cnt + 4'h1;
                st <= S_ACK;
                o_sda_oe <= 1'b1;
              end else begin
                st <= S_IDLE;
              end
            end
          end
          S_ACK: begin
            if (scl_fall) begin
              bit_cnt <= 4'h0;
              if (is_read) begin
                st <= S_RD;
                tx_sh <= sel_byte;
                o_sda_oe <= !sel_byte[7];
              end else begin
                st <= S_WR;
                o_sda_oe <= 1'b0;
              end
            end
          end
          S_RD: begin
            if (scl_fall) begin
              if (bit_cnt == flow_cmd_pkg::BIT_LAST) begin
                st <= S_RD_ACK;
                o_sda_oe <= 1'b0;
              end else begin
                bit_cnt <= bit_cnt + 4'h1;
                tx_sh <= {tx_sh[6:0], 1'b0};
                o_sda_oe <= !tx_sh[6];
              end
            end
          end
          S_RD_ACK: begin
            if (scl_rise) begin
              master_ack <= !sda_s2;
            end else if (scl_fall) begin
              bit_cnt <= 4'h0;
              if (master_ack && rd_idx < flow_cmd_pkg::RD_LAST_IDX) begin
                rd_idx <= rd_idx + 4'h1;
                st <= S_RD;
                tx_sh <= sel_byte;
                o_sda_oe <= !sel_byte[7];
              end else begin
                st <= S_IDLE;
              end
            end
          end
          default: begin
            st <= S_IDLE;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // command execution and measurement state
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      mst <= M_IDLE;
      wait_cnt <= 20'h0_0000;
      o_meas_mode <= flow_cmd_pkg::MODE_O2;
      o_conc <= flow_cmd_pkg::CONC_PURE;
      ptr_moved <= 1'b0;
      o_cmd_reject <= 1'b0;
    end else begin
      o_cmd_reject <= 1'b0;
      case (mst)
        M_IDLE: begin
          if (exec) begin
            if (wr_cnt == flow_cmd_pkg::WR_BYTES_PLAIN &&
                (cmd == flow_cmd_pkg::CMD_START_O2 || cmd == flow_cmd_pkg::CMD_START_AIR)) begin
              mst <= M_WARM;
              wait_cnt <= 20'h0_0000;
              ptr_moved <= 1'b0;
              o_conc <= flow_cmd_pkg::CONC_PURE;
              o_meas_mode <= (cmd == flow_cmd_pkg::CMD_START_O2) ?
                             flow_cmd_pkg::MODE_O2 : flow_cmd_pkg::MODE_AIR;
            end else if (cmd == flow_cmd_pkg::CMD_START_MIX && arg_ok &&
                         arg <= flow_cmd_pkg::CONC_MAX) begin
              mst <= M_WARM;
              wait_cnt <= 20'h0_0000;
              ptr_moved <= 1'b0;
              o_conc <= arg[9:0];
              o_meas_mode <= flow_cmd_pkg::MODE_MIX;
            end else begin
              o_cmd_reject <= 1'b1;
            end
          end
        end
        M_WARM, M_RUN: begin
          if (mst == M_WARM) begin
            if (wait_cnt >= 20'(WARM_CYC - 1)) begin
              mst <= M_RUN;
            end else begin
              wait_cnt <= wait_cnt + 20'h0_0001;
            end
          end
          if (exec) begin
            if (wr_cnt == flow_cmd_pkg::WR_BYTES_PLAIN && cmd == flow_cmd_pkg::CMD_STOP) begin
              mst <= M_STOPPING;
              wait_cnt <= 20'h0_0000;
            end else if (cmd == flow_cmd_pkg::CMD_CONC && arg_ok) begin
              if (arg > flow_cmd_pkg::CONC_MAX) begin
                mst <= M_STOPPING;
                wait_cnt <= 20'h0_0000;
              end else begin
                o_conc <= arg[9:0];
                ptr_moved <= 1'b1;
              end
            end else if (wr_cnt == flow_cmd_pkg::WR_BYTES_PLAIN &&
                         cmd == flow_cmd_pkg::CMD_PTR_RESET) begin
              ptr_moved <= 1'b0;
            end else begin
              o_cmd_reject <= 1'b1;
            end
          end
        end
        M_STOPPING: begin
          ptr_moved <= 1'b0;
          if (wait_cnt >= 20'(STOP_CYC - 1)) begin
            mst <= M_IDLE;
          end else begin
            wait_cnt <= wait_cnt + 20'h0_0001;
          end
        end
        default: begin
          mst <= M_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // average-until-read smoothing watch
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      avg_cnt <= 20'h0_0000;
      exp_on <= 1'b0;
    end else if (mst != M_RUN || i_avg_fixed || rd_event) begin
      avg_cnt <= 20'h0_0000;
      exp_on <= 1'b0;
    end else if (avg_cnt >= 20'(SMOOTH_CYC - 1)) begin
      exp_on <= 1'b1;
    end else begin
      avg_cnt <= avg_cnt + 20'h0_0001;
    end
  end

  // ----------------------------------------------------------------
  // status outputs
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_meas_active <= 1'b0;
      o_data_ready <= 1'b0;
      o_exp_smooth <= 1'b0;
    end else begin
      o_meas_active <= (mst == M_WARM) || (mst == M_RUN);
      o_data_ready <= rd_ok;
      o_exp_smooth <= exp_on;
    end
  end

endmodule : flow_cmd_target

`default_nettype wire

// [verification/flow_cmd_target_chk.sv]
`timescale 1ns/1ps
`default_nettype none

module flow_cmd_target_chk #(
  parameter int WARM_CYC = 200,
  parameter int STOP_CYC = 50,
  parameter int SMOOTH_CYC = 400
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // serial link pins
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic o_sda_out,
  input wire logic o_sda_oe,
  // measurement results
  input wire logic [15:0] i_flow,
  input wire logic [15:0] i_temp,
  input wire logic i_avg_fixed,
  // control and status
  input wire logic o_meas_active,
  input wire logic o_data_ready,
  input wire logic [3:0] o_meas_mode,
  input wire logic [9:0] o_conc,
  input wire logic o_exp_smooth,
  input wire logic o_cmd_reject
);
  int act_cnt;
  int hi_cnt;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  // ------------------------------
  // helper counters
  // ------------------------------
  always_ff @(posedge i_clk) begin
    act_cnt <= (i_sys_rst || !o_meas_active) ? 0 : act_cnt + 1;
  end

  always_ff @(posedge i_clk) begin
    hi_cnt <= (i_sys_rst || !i_scl) ? 0 : hi_cnt + 1;
  end

  // ------------------------------
  // assertions
  // ------------------------------
  sequence s_state_held;
    $stable(o_meas_mode) && $stable(o_conc) && $stable(o_meas_active);
  endsequence

  ready_in_run_a: assert property (o_data_ready |-> o_meas_active)
    else $error("data ready outside measurement");
  warm_wait_a: assert property ($rose(o_data_ready) |-> act_cnt >= WARM_CYC - 2)
    else $error("data ready before warm-up ended");
  sda_scl_low_a: assert property ($changed(o_sda_oe) |-> !$past(i_scl, 2))
    else $error("data line changed while clock high");
  idle_release_a: assert property (hi_cnt > 6 |-> !o_sda_oe)
    else $error("data line held outside a frame");
  reject_pulse_a: assert property (o_cmd_reject |=> !o_cmd_reject)
    else $error("reject pulse too long");
  reject_keep_a: assert property (o_cmd_reject |-> s_state_held ##1 s_state_held)
    else $error("refused command changed state");
  mode_code_a: assert property (o_meas_active |-> o_meas_mode inside {4'h0, 4'h1, 4'h6})
    else $error("illegal mode code");
  pure_conc_a: assert property (o_meas_active && o_meas_mode != 4'h6 |-> o_conc == 10'h3FF)
    else $error("pure gas concentration wrong");
  mix_conc_a: assert property (o_meas_active && o_meas_mode == 4'h6 |-> o_conc <= 10'd1000)
    else $error("mixture above limit kept running");
  smooth_late_a: assert property ($rose(o_exp_smooth) |->
    act_cnt >= WARM_CYC + SMOOTH_CYC - 2 && !i_avg_fixed)
    else $error("smoothing switched on too early");

endmodule : flow_cmd_target_chk

bind flow_cmd_target flow_cmd_target_chk #(
  .WARM_CYC(WARM_CYC), .STOP_CYC(STOP_CYC), .SMOOTH_CYC(SMOOTH_CYC)
) u_chk (
  .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_scl(i_scl), .i_sda(i_sda),
  .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe), .i_flow(i_flow), .i_temp(i_temp),
  .i_avg_fixed(i_avg_fixed), .o_meas_active(o_meas_active), .o_data_ready(o_data_ready),
  .o_meas_mode(o_meas_mode), .o_conc(o_conc), .o_exp_smooth(o_exp_smooth),
  .o_cmd_reject(o_cmd_reject)
);

`default_nettype wire

// [verification/i2c_host_model.sv]
`timescale 1ns/1ps
`default_nettype none

module i2c_host_model (
  // clock
  input wire logic i_clk,
  // bus lines
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_oe
);
  initial begin
    o_scl = 1'b1;
    o_sda_oe = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask : tick

  // ------------------------------
  // bus conditions, clock low after start, high after stop
  // ------------------------------
  task automatic start();
    o_sda_oe <= 1'b0;
    tick(2);
    o_scl <= 1'b1;
    tick(2);
    o_sda_oe <= 1'b1;
    tick(2);
    o_scl <= 1'b0;
    tick(1);
  endtask : start

  task automatic stop();
    o_sda_oe <= 1'b1;
    tick(2);
    o_scl <= 1'b1;
    tick(2);
    o_sda_oe <= 1'b0;
    tick(4);
  endtask : stop

  // one bit: data set with clock low, sampled mid-high
  task automatic bitx(input logic b, output logic r);
    o_sda_oe <= !b;
    tick(3);
    o_scl <= 1'b1;
    tick(2);
    r = i_sda;
    tick(2);
    o_scl <= 1'b0;
    tick(1);
  endtask : bitx

  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(d[i], r);
    bitx(1'b1, r);
    ack = !r;
  endtask : wbyte

  // last byte answered with nack, caller then stops
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitx(1'b1, r);
      d[i] = r;
    end
    bitx(last, r);
  endtask : rbyte

endmodule : i2c_host_model

`default_nettype wire

// [verification/flow_cmd_target_tb.sv]
`timescale 1ns/1ps
`default_nettype none

module flow_cmd_target_tb;
  localparam int WARM = 200;
  localparam int STOPW = 50;
  localparam int SMOOTH = 400;
  logic i_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic [15:0] i_flow = 16'h0000;
  logic [15:0] i_temp = 16'h0000;
  logic i_avg_fixed = 1'b1;
  logic scl, host_oe, sda_out, dut_oe, active, ready, smooth, reject, ak;
  logic [3:0] mode;
  logic [9:0] conc;
  logic [15:0] a;
  logic [15:0] rsv[5] = '{16'h3615, 16'h361E, 16'h3624, 16'h362F, 16'hE000};
  wire logic sda;
  int num_errors = 0;
  int comparisons = 0;
  int rej_cnt = 0;
  int cyc = 0;
  int t_cmd = 0;
  int m_rdy = 0;
  int m_mode = 0;
  int m_conc = 1023;

  flow_cmd_target #(.WARM_CYC(WARM), .STOP_CYC(STOPW), .SMOOTH_CYC(SMOOTH)) u_dut (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_scl(scl), .i_sda(sda), .o_sda_out(sda_out),
    .o_sda_oe(dut_oe), .i_flow(i_flow), .i_temp(i_temp), .i_avg_fixed(i_avg_fixed),
    .o_meas_active(active), .o_data_ready(ready), .o_meas_mode(mode), .o_conc(conc),
    .o_exp_smooth(smooth), .o_cmd_reject(reject)
  );
  i2c_host_model u_host (.i_clk(i_clk), .i_sda(sda), .o_scl(scl), .o_sda_oe(host_oe));

  // open-drain wire with pull-up
  assign sda = (dut_oe ? sda_out : 1'b1) & !host_oe;

  always #50 i_clk = ~i_clk;

  always @(posedge i_clk) begin
    cyc++;
    if (reject) rej_cnt++;
  end

  // ------------------------------
  // checking and model helpers
  // ------------------------------
  task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] x);
    comparisons++;
    if (s !== x) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", nm, x, s);
    end
  endtask : chk

  task automatic stop_test();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : stop_test

  function automatic logic [7:0] crc8(input logic [15:0] w);
    logic [7:0] c;
    c = flow_cmd_pkg::CRC_INIT;
    for (int i = 15; i >= 0; i--) begin
      c = (c[7] ^ w[i]) ? {c[6:0], 1'b0} ^ flow_cmd_pkg::CRC_POLY : {c[6:0], 1'b0};
    end
    return c;
  endfunction : crc8

  task automatic wr(input logic [15:0] c, input logic [15:0] x, input int n,
                    input logic [7:0] bad, input logic er);
    logic [7:0] b[5];
    int r0;
    b = '{c[15:8], c[7:0], x[15:8], x[7:0], crc8(x) ^ bad};
    r0 = rej_cnt;
    u_host.start();
    u_host.wbyte({flow_cmd_pkg::TARGET_ADDR, 1'b0}, ak);
    for (int i = 0; i < n; i++) u_host.wbyte(b[i], ak);
    u_host.stop();
    t_cmd = cyc;
    u_host.tick(4);
    chk("reject", 16'(rej_cnt - r0), 16'(er));
  endtask : wr

  task automatic rd(input int n);
    logic [7:0] d;
    logic [15:0] w[3];
    logic [7:0] e[$];
    i_flow <= 16'($urandom);
    i_temp <= 16'($urandom);
    u_host.tick(1);
    w = '{i_flow, i_temp, {m_mode[3:0], 1'b0, i_avg_fixed, m_conc[9:0]}};
    chk("ready", 16'(ready), 16'(m_rdy));
    u_host.start();
    u_host.wbyte({flow_cmd_pkg::TARGET_ADDR, 1'b1}, ak);
    chk("rd_ack", 16'(ak), 16'(m_rdy));
    if (ak === 1'b1) begin
      for (int i = 0; i < 3; i++) e = {e, w[i][15:8], w[i][7:0], crc8(w[i])};
      for (int i = 0; i < n; i++) begin
        u_host.rbyte(i == n - 1, d);
        chk("rd_byte", 16'(d), 16'(e[i]));
      end
    end
    u_host.stop();
  endtask : rd

  task automatic wait_rdy();
    int k;
    k = 0;
    while (ready !== 1'b1 && k < 2 * WARM) begin
      u_host.tick(1);
      k++;
    end
    if (k == 2 * WARM) begin
      chk("ready_wait", 16'h0000, 16'h0001);
      stop_test();
    end
    chk("warm_time", 16'(cyc - t_cmd >= WARM - 8 && cyc - t_cmd <= WARM + 8), 16'h0001);
  endtask : wait_rdy

  // ------------------------------
  // main sequence
  // ------------------------------
  initial begin
    void'($urandom(83426));
    repeat (2) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    repeat (4) @(posedge i_clk);
    chk("rst_conc", 16'(conc), 16'h03FF);
    u_host.start();
    u_host.wbyte(8'h54, ak);
    u_host.stop();
    chk("bad_addr", 16'(ak), 16'h0000);
    rd(9);
    foreach (rsv[i]) wr(rsv[i], 16'h0000, 2, 8'h00, 1'b1);
    wr(16'h3632, 16'd1001, 5, 8'h00, 1'b1);
    chk("idle", 16'(active), 16'h0000);
    wr(16'h3608, 16'h0000, 2, 8'h00, 1'b0);
    m_mode = 1;
    rd(9);
    wait_rdy();
    m_rdy = 1;
    chk("mode_air", 16'(mode), 16'(m_mode));
    rd(9);
    rd(9);
    wr(16'h3603, 16'h0000, 2, 8'h00, 1'b1);
    rd(9);
    i_avg_fixed <= 1'b0;
    u_host.tick(SMOOTH + 20);
    chk("smooth_on", 16'(smooth), 16'h0001);
    rd(3);
    chk("smooth_off", 16'(smooth), 16'h0000);
    chk("released", 16'(dut_oe), 16'h0000);
    i_avg_fixed <= 1'b1;
    wr(16'h3FF9, 16'h0000, 2, 8'h00, 1'b0);
    m_rdy = 0;
    chk("stopped", 16'(active), 16'h0000);
    u_host.tick(STOPW);
    a = 16'($urandom_range(1000));
    wr(16'h3632, a, 5, 8'h00, 1'b0);
    m_mode = 6;
    m_conc = a;
    wait_rdy();
    m_rdy = 1;
    chk("mode_mix", 16'(mode), 16'(m_mode));
    rd(9);
    wr(16'hE17D, 16'($urandom_range(1000)), 5, 8'h01, 1'b1);
    rd(9);
    u_host.tick(10100);
    a = 16'($urandom_range(1000));
    wr(16'hE17D, a, 5, 8'h00, 1'b0);
    chk("ptr_moved", 16'(ready), 16'h0000);
    chk("still_on", 16'(active), 16'h0001);
    wr(16'hE000, 16'h0000, 2, 8'h00, 1'b0);
    m_conc = a;
    rd(9);
    u_host.tick(10100);
    wr(16'hE17D, 16'd1001, 5, 8'h00, 1'b0);
    chk("over_stop", 16'(active), 16'h0000);
    stop_test();
  end

endmodule : flow_cmd_target_tb

`default_nettype wire
